// *** hw/pps_output_select.sv ***
// peripheral output pin select: per-pin selectors and muxes
`timescale 1ns/1ns
module pps_output_select #(
  parameter int NUM_PINS = 16
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sel_wr_i,
  input wire logic [$clog2(NUM_PINS)-1:0] sel_pin_i,
  input wire logic [pps_pkg::SEL_W-1:0] sel_data_i,
  input wire logic comparator_a_output_i,
  input wire logic comparator_b_output_i,
  input wire logic uart_a_transmit_i,
  input wire logic uart_a_request_to_send_i,
  input wire logic uart_b_transmit_i,
  input wire logic uart_b_request_to_send_i,
  input wire logic spi_a_serial_out_i,
  input wire logic spi_a_clock_out_i,
  input wire logic spi_a_select_out_i,
  input wire logic spi_b_serial_out_i,
  input wire logic spi_b_clock_out_i,
  input wire logic spi_b_select_out_i,
  input wire logic codec_serial_out_i,
  input wire logic codec_clock_out_i,
  input wire logic codec_frame_sync_out_i,
  input wire logic can_a_transmit_i,
  input wire logic compare_channel_a_out_i,
  input wire logic compare_channel_b_out_i,
  input wire logic compare_channel_c_out_i,
  input wire logic compare_channel_d_out_i,
  input wire logic [NUM_PINS-1:0] port_out_i,
  input wire logic [NUM_PINS-1:0] port_oe_i,
  output logic [NUM_PINS*pps_pkg::SEL_W-1:0] pin_output_map_reg_o,
  output logic [NUM_PINS-1:0] remappable_pin_o,
  output logic [NUM_PINS-1:0] remappable_pin_oe_o,
  output logic [NUM_PINS-1:0] pin_mapped_o
);
  // ****************************************
  // source vector, indexed by selector code
  // ****************************************
  logic [pps_pkg::NUM_SRC-1:0] src;
  logic [pps_pkg::SEL_W-1:0] pin_output_selector [NUM_PINS];
  logic [NUM_PINS-1:0] pin_wr_hit;

  // ****************************************
  // write address decode
  // ****************************************
  localparam int IDX_W = $clog2(NUM_PINS);

  // true when a write strobe addresses the given pin
  function automatic logic pin_addr_hit(
    input logic wr,
    input logic [IDX_W-1:0] addr,
    input int unsigned pin
  );
    return wr && (addr == IDX_W'(pin));
  endfunction

  // null code and the spare code between can and compare carry no source
  assign src[pps_pkg::SEL_NULL] = 1'b0;
  assign src[5'h11] = 1'b0;

  // comparator outputs
  assign src[pps_pkg::SEL_CMP_A] = comparator_a_output_i;
  assign src[pps_pkg::SEL_CMP_B] = comparator_b_output_i;

  // uart transmit and request-to-send lines
  assign src[pps_pkg::SEL_UART_A_TX] = uart_a_transmit_i;
  assign src[pps_pkg::SEL_UART_A_RTS] = uart_a_request_to_send_i;
  assign src[pps_pkg::SEL_UART_B_TX] = uart_b_transmit_i;
  assign src[pps_pkg::SEL_UART_B_RTS] = uart_b_request_to_send_i;

  // spi data, clock and select outputs
  assign src[pps_pkg::SEL_SPI_A_SDO] = spi_a_serial_out_i;
  assign src[pps_pkg::SEL_SPI_A_SCK] = spi_a_clock_out_i;
  assign src[pps_pkg::SEL_SPI_A_SS] = spi_a_select_out_i;
  assign src[pps_pkg::SEL_SPI_B_SDO] = spi_b_serial_out_i;
  assign src[pps_pkg::SEL_SPI_B_SCK] = spi_b_clock_out_i;
  assign src[pps_pkg::SEL_SPI_B_SS] = spi_b_select_out_i;

  // codec interface outputs
  assign src[pps_pkg::SEL_CODEC_SDO] = codec_serial_out_i;
  assign src[pps_pkg::SEL_CODEC_SCK] = codec_clock_out_i;
  assign src[pps_pkg::SEL_CODEC_FS] = codec_frame_sync_out_i;

  // can transmit line
  assign src[pps_pkg::SEL_CAN_A_TX] = can_a_transmit_i;

  // output compare channels
  assign src[pps_pkg::SEL_CMPCH_A] = compare_channel_a_out_i;
  assign src[pps_pkg::SEL_CMPCH_B] = compare_channel_b_out_i;
  assign src[pps_pkg::SEL_CMPCH_C] = compare_channel_c_out_i;
  assign src[pps_pkg::SEL_CMPCH_D] = compare_channel_d_out_i;

  // ****************************************
  // per-pin selector fields and muxes
  // ****************************************
  for (genvar p = 0; p < NUM_PINS; p++)
  begin : g_pin
    // address decode; out of range indices hit no pin
    assign pin_wr_hit[p] = pin_addr_hit(sel_wr_i, sel_pin_i, p);

    // selector write, reset to null code
    always_ff @(posedge clk_i)
    begin
      if (!reset_n_i)
        pin_output_selector[p] <= pps_pkg::SEL_RESET;
      else if (pin_wr_hit[p])
        pin_output_selector[p] <= sel_data_i;
    end

    assign pin_output_map_reg_o[p*pps_pkg::SEL_W +: pps_pkg::SEL_W] = pin_output_selector[p];

    pps_pin_mux u_mux (
      .pin_output_selector_i(pin_output_selector[p]),
      .src_i(src),
      .port_out_i(port_out_i[p]),
      .port_oe_i(port_oe_i[p]),
      .pin_out_o(remappable_pin_o[p]),
      .pin_oe_o(remappable_pin_oe_o[p]),
      .pin_mapped_o(pin_mapped_o[p])
    );
  end
endmodule

// *** inc/pps_pkg.sv ***
// constants for the peripheral output pin select block
//
// Summary of operation
// - each remappable pin owns its own 5-bit output selector field
// - the source named by a pin's selector drives that pin
// - code 00000 leaves the pin on its default port logic
// - codes 00001 and 00010 select comparator a and b outputs
// - codes 00011 and 00100 select uart a transmit and request-to-send
// - codes 00101 and 00110 select uart b transmit and request-to-send
// - codes 00111, 01000, 01001 select spi a data, clock, select
// - codes 01010, 01011, 01100 select spi b data, clock, select
// - codes 01101, 01110, 01111 select codec data, clock, frame sync
// - code 10000 selects can a transmit
// - codes 10010, 10011, 10100 select compare channels a, b, c
// - code 10101 selects compare channel d
package pps_pkg;
  localparam int SEL_W = 5;
  localparam int NUM_SRC = 22;
  localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
  localparam logic [SEL_W-1:0] SEL_NULL = 5'h00;
  localparam logic [SEL_W-1:0] SEL_CMP_A = 5'h01;
  localparam logic [SEL_W-1:0] SEL_CMP_B = 5'h02;
  localparam logic [SEL_W-1:0] SEL_UART_A_TX = 5'h03;
  localparam logic [SEL_W-1:0] SEL_UART_A_RTS = 5'h04;
  localparam logic [SEL_W-1:0] SEL_UART_B_TX = 5'h05;
  localparam logic [SEL_W-1:0] SEL_UART_B_RTS = 5'h06;
  localparam logic [SEL_W-1:0] SEL_SPI_A_SDO = 5'h07;
  localparam logic [SEL_W-1:0] SEL_SPI_A_SCK = 5'h08;
  localparam logic [SEL_W-1:0] SEL_SPI_A_SS = 5'h09;
  localparam logic [SEL_W-1:0] SEL_SPI_B_SDO = 5'h0A;
  localparam logic [SEL_W-1:0] SEL_SPI_B_SCK = 5'h0B;
  localparam logic [SEL_W-1:0] SEL_SPI_B_SS = 5'h0C;
  localparam logic [SEL_W-1:0] SEL_CODEC_SDO = 5'h0D;
  localparam logic [SEL_W-1:0] SEL_CODEC_SCK = 5'h0E;
  localparam logic [SEL_W-1:0] SEL_CODEC_FS = 5'h0F;
  localparam logic [SEL_W-1:0] SEL_CAN_A_TX = 5'h10;
  localparam logic [SEL_W-1:0] SEL_CMPCH_A = 5'h12;
  localparam logic [SEL_W-1:0] SEL_CMPCH_B = 5'h13;
  localparam logic [SEL_W-1:0] SEL_CMPCH_C = 5'h14;
  localparam logic [SEL_W-1:0] SEL_CMPCH_D = 5'h15;
endpackage

// *** hw/pps_pin_mux.sv ***
// one remappable pin's output multiplexer
`timescale 1ns/1ns
module pps_pin_mux (
  input wire logic [pps_pkg::SEL_W-1:0] pin_output_selector_i,
  input wire logic [pps_pkg::NUM_SRC-1:0] src_i,
  input wire logic port_out_i,
  input wire logic port_oe_i,
  output logic pin_out_o,
  output logic pin_oe_o,
  output logic pin_mapped_o
);
  // source index: bit n of src_i corresponds to code n
  always_comb
  begin
    pin_out_o = port_out_i;
    pin_oe_o = port_oe_i;
    pin_mapped_o = 1'b0;
    case (pin_output_selector_i)
      pps_pkg::SEL_CMP_A, pps_pkg::SEL_CMP_B,
      pps_pkg::SEL_UART_A_TX, pps_pkg::SEL_UART_A_RTS,
      pps_pkg::SEL_UART_B_TX, pps_pkg::SEL_UART_B_RTS,
      pps_pkg::SEL_SPI_A_SDO, pps_pkg::SEL_SPI_A_SCK, pps_pkg::SEL_SPI_A_SS,
      pps_pkg::SEL_SPI_B_SDO, pps_pkg::SEL_SPI_B_SCK, pps_pkg::SEL_SPI_B_SS,
      pps_pkg::SEL_CODEC_SDO, pps_pkg::SEL_CODEC_SCK, pps_pkg::SEL_CODEC_FS,
      pps_pkg::SEL_CAN_A_TX,
      pps_pkg::SEL_CMPCH_A, pps_pkg::SEL_CMPCH_B, pps_pkg::SEL_CMPCH_C,
      pps_pkg::SEL_CMPCH_D:
      begin
        pin_out_o = src_i[pin_output_selector_i];
        pin_oe_o = 1'b1;
        pin_mapped_o = 1'b1;
      end
      default:
      begin
        pin_out_o = port_out_i;
        pin_oe_o = port_oe_i;
        pin_mapped_o = 1'b0;
      end
    endcase
  end
endmodule

// *** testbench/pps_output_select_props.sv ***
// checker for the output pin select block
`timescale 1ns/1ns
module pps_output_select_props #(
  parameter int NUM_PINS = 16
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sel_wr_i,
  input wire logic comparator_a_output_i,
  input wire logic can_a_transmit_i,
  input wire logic compare_channel_d_out_i,
  input wire logic [$clog2(NUM_PINS)-1:0] sel_pin_i,
  input wire logic [4:0] sel_data_i,
  input wire logic [NUM_PINS-1:0] port_out_i,
  input wire logic [NUM_PINS-1:0] port_oe_i,
  input wire logic [NUM_PINS-1:0] remappable_pin_o,
  input wire logic [NUM_PINS-1:0] remappable_pin_oe_o,
  input wire logic [NUM_PINS-1:0] pin_mapped_o,
  input wire logic [NUM_PINS*5-1:0] pin_output_map_reg_o
);
  // pin 0 selector and data
  wire [4:0] s0 = pin_output_map_reg_o[4:0];
  wire p = remappable_pin_o[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_write_lands: assert property (sel_wr_i && sel_pin_i < NUM_PINS
    |=> pin_output_map_reg_o[5*$past(sel_pin_i)+:5] == $past(sel_data_i)) else $error("write lost");
  chk_map_holds: assert property (!sel_wr_i |=> $stable(pin_output_map_reg_o)) else $error("map moved");
  chk_null_port: assert property (s0 == 5'h00 |-> p == port_out_i[0] && !pin_mapped_o[0]) else $error("null");
  chk_cmp_a: assert property (s0 == 5'h01 |-> p == comparator_a_output_i) else $error("cmp a");
  chk_can_a: assert property (s0 == 5'h10 |-> p == can_a_transmit_i) else $error("can a");
  chk_cmpch_d: assert property (s0 == 5'h15 |-> p == compare_channel_d_out_i) else $error("compare d");
  chk_stray_ignored: assert property (sel_wr_i && sel_pin_i >= NUM_PINS
    |=> $stable(pin_output_map_reg_o)) else $error("stray write");
  chk_spare_null: assert property (s0 == 5'h11 || s0 > 5'h15 |-> !pin_mapped_o[0]) else $error("spare");
  chk_mapped_oe: assert property (pin_mapped_o[0] |-> remappable_pin_oe_o[0]) else $error("oe");
  chk_port_oe: assert property (!pin_mapped_o[0] |-> remappable_pin_oe_o[0] == port_oe_i[0]) else $error("port oe");
  cover property (s0 == 5'h15);
  cover property (sel_wr_i && sel_pin_i >= NUM_PINS);
  cover property (sel_wr_i ##1 sel_wr_i);
endmodule
bind pps_output_select pps_output_select_props #(.NUM_PINS(NUM_PINS)) pps_output_select_props_i (.*);

// *** testbench/pps_src_model.sv ***
// peripheral output sources feeding the pin select block
`timescale 1ns/1ns
module pps_src_model (
  input wire logic clk_i,
  output logic [19:0] src_o
);
  logic [19:0] pattern = 20'h00000;

  // johnson pattern so each source toggles often
  always @(posedge clk_i) pattern <= #2 {pattern[18:0], ~pattern[19]};
  assign src_o = pattern;
endmodule

// *** testbench/tb_pps_output_select.sv ***
// testbench for the output pin select block
`timescale 1ns/1ns
module tb_pps_output_select;
  logic clk_i = 1'b0, reset_n_i = 1'b0, sel_wr_i = 1'b0;
  logic [3:0] sel_pin_i = 4'h0;
  logic [4:0] sel_data_i = 5'h00;
  logic [11:0] port_out_i = 12'hA5C, port_oe_i = 12'h3C9, pin, oe, mapd;
  logic [59:0] map, exp_map = 60'h0;
  logic [19:0] s;
  int error_cnt = 0, checks_done = 0, p;
  pps_src_model pps_src_model_i (.clk_i(clk_i), .src_o(s));
  pps_output_select #(.NUM_PINS(12)) pps_output_select_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .sel_wr_i(sel_wr_i), .sel_pin_i(sel_pin_i), .sel_data_i(sel_data_i), .comparator_a_output_i(s[0]),
    .comparator_b_output_i(s[1]), .uart_a_transmit_i(s[2]), .uart_a_request_to_send_i(s[3]),
    .uart_b_transmit_i(s[4]), .uart_b_request_to_send_i(s[5]), .spi_a_serial_out_i(s[6]),
    .spi_a_clock_out_i(s[7]), .spi_a_select_out_i(s[8]), .spi_b_serial_out_i(s[9]), .spi_b_clock_out_i(s[10]),
    .spi_b_select_out_i(s[11]), .codec_serial_out_i(s[12]), .codec_clock_out_i(s[13]),
    .codec_frame_sync_out_i(s[14]), .can_a_transmit_i(s[15]), .compare_channel_a_out_i(s[16]),
    .compare_channel_b_out_i(s[17]), .compare_channel_c_out_i(s[18]), .compare_channel_d_out_i(s[19]),
    .port_out_i(port_out_i), .port_oe_i(port_oe_i), .pin_output_map_reg_o(map), .remappable_pin_o(pin),
    .remappable_pin_oe_o(oe), .pin_mapped_o(mapd));
  initial forever #5 clk_i = ~clk_i;
  // compare and count
  task automatic check(input logic [59:0] seen, input logic [59:0] want);
    checks_done++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // one selector write, back to back when called again
  task automatic wr(input logic [3:0] a, input logic [4:0] d);
    sel_wr_i = 1'b1;
    sel_pin_i = a;
    sel_data_i = d;
    @(posedge clk_i) #1;
    if (a < 12) exp_map[5*a+:5] = d;
  endtask
  // expected data, enable, mapped
  function automatic logic [2:0] exp(input logic [4:0] c, input logic d, input logic e);
    if (c >= 5'h01 && c <= 5'h10) return {s[c-1], 2'b11};
    if (c >= 5'h12 && c <= 5'h15) return {s[c-2], 2'b11};
    return {d, e, 1'b0};
  endfunction
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // every code on pin 0, inverse code on a second pin, stray index
  initial
  begin
    repeat (12) @(posedge clk_i) #1;
    check(map, 60'h0);
    reset_n_i = 1'b1;
    for (int c = 0; c < 32; c++)
    begin
      p = c % 11 + 1;
      wr(4'h0, c[4:0]);
      wr(p[3:0], ~c[4:0]);
      wr(4'hD, 5'h1F);
      sel_wr_i = 1'b0;
      port_out_i = ~port_out_i;
      port_oe_i = port_oe_i ^ 12'h0F3;
      @(posedge clk_i) #1;
      check(map, exp_map);
      check({pin[0], oe[0], mapd[0]}, exp(c[4:0], port_out_i[0], port_oe_i[0]));
      check({pin[p], oe[p], mapd[p]}, exp(~c[4:0], port_out_i[p], port_oe_i[p]));
    end
    reset_n_i = 1'b0;
    @(posedge clk_i) #1;
    check(map, 60'h0);
    check({pin, oe, mapd}, {port_out_i, port_oe_i, 12'h000});
    // release again and write at the very next edge
    reset_n_i = 1'b1;
    exp_map = 60'h0;
    wr(4'h5, 5'h15);
    sel_wr_i = 1'b0;
    check(map, exp_map);
    check({pin[5], oe[5], mapd[5]}, exp(5'h15, port_out_i[5], port_oe_i[5]));
    check({pin[0], oe[0], mapd[0]}, exp(5'h00, port_out_i[0], port_oe_i[0]));
    end_sim();
  end
  initial
  begin
    #20000;
    error_cnt++;
    end_sim();
  end
endmodule
